// File: design/dual_vectored_interrupt_ctrl.sv
// Dual vectored interrupt controller: two chained 16-channel units.
// Assumes all request inputs are asynchronous levels and the core acknowledges with a one-cycle read pulse.
`timescale 1ns/1ps
`include "intc_params.svh"

// Operation
// [RULE_01] Thirty-two channels feed a fast and a normal request; fast is higher.
// [RULE_02] Fast request is non-vectored; any channel can be routed to it.
// [RULE_03] Normal request is OR of all vectored channel requests.
// [RULE_04] Channel 0 highest priority, channel 31 lowest, fixed in hardware.
// [RULE_05] Firmware remaps sources to slots only within their own unit.
// [RULE_06] Primary unit requests always beat secondary unit requests.
// [RULE_07] Priority resolves first, then service read returns source and vector.
// [RULE_08] Vector fetch instruction held in a dedicated cache entry, one access.
// [RULE_09] Five channels from wake-up unit, twenty-seven from on-chip sources.
// [RULE_10] Firmware can force a pending interrupt on any channel.
// [RULE_11] Channel 25 is OR of all thirty-two wake-up inputs.
// [RULE_12] Channels 26 to 29 are ORs of eight-source wake-up groups.
// [RULE_13] Channel 0 is the watchdog timeout or terminal count.
// [RULE_14] Channels 4 to 7 carry the four ORed timer requests.
// [RULE_15] Channel 8 serial bus high-priority OR, channel 9 low-priority OR.
// [RULE_16] Channels 10,11,13,14,15: clock, network, field bus, motor, converter.
// [RULE_17] Channel 12 is OR of the eight transfer engine channels.
// [RULE_18] Channels 16 to 18 carry the three asynchronous serial ports.
// [RULE_19] Channels 19,20 two-wire ports; 21,22 synchronous serial ports.
// [RULE_20] Channel 23 low-voltage warning, channel 24 real-time clock OR.
// [RULE_21] Channel 30 bus resume wake-up, channel 31 prefetch and branch cache.
// [RULE_22] Channels 1 to 3: firmware interrupt, debug receive, debug transmit.
// [RULE_23] Secondary unit forwards its resolved request into primary chain input.
module dual_vectored_interrupt_ctrl (
    // Clock and reset
    input  wire logic             clock,
    input  wire logic             srst,
    // Peripheral and wake-up request lines
    input  wire intc_pkg::periph_s periph,
    input  wire logic [31:0]      wake_in,
    input  wire logic             fw_soft_irq,
    // Firmware configuration
    input  wire intc_pkg::ch_vec_t fast_sel,
    input  wire intc_pkg::ch_vec_t force_pend,
    input  wire intc_pkg::ch_vec_t ch_enable,
    input  wire logic [63:0]      prim_map,
    input  wire logic [63:0]      sec_map,
    input  wire intc_pkg::vec_t   vec_base,
    // Core side
    input  wire logic             vec_read,
    output logic                  fast_irq_out,
    output logic                  normal_irq_out,
    output intc_pkg::ch_idx_t     src_out,
    output intc_pkg::vec_t        vec_out,
    output logic                  vec_valid,
    output intc_pkg::vec_t        cache_vec_instr
);
    import intc_pkg::*;

    // ****************************************
    // Input synchronisation
    // ****************************************
    localparam int RAW_W = $bits(periph_s) + 33;
    logic [RAW_W-1:0] sync1_r;
    logic [RAW_W-1:0] sync2_r;
    always_ff @(posedge clock) begin
        sync1_r <= {periph, wake_in, fw_soft_irq};
        sync2_r <= sync1_r;
    end
    periph_s     p;
    logic [31:0] wk;
    logic        fw_s;
    assign p    = sync2_r[RAW_W-1:33];
    assign wk   = sync2_r[32:1];
    assign fw_s = sync2_r[0];

    // ****************************************
    // Source assignment
    // ****************************************
    // Wake-up group 0 is alarm, resume and six port pins; pins sit in wk[29:0] in port order.
    ch_vec_t     raw;
    logic [7:0]  wgrp0;
    assign wgrp0 = {wk[`WAKE_RESUME_BIT], wk[`WAKE_ALARM_BIT], wk[5:0]}; // RULE_12
    assign raw[`CH_WATCHDOG]          = p.watchdog;                      // RULE_13
    assign raw[`CH_FW_SOFT]           = fw_s;                            // RULE_22
    assign raw[`CH_DBG_RX]            = p.dbg_rx;                        // RULE_22
    assign raw[`CH_DBG_TX]            = p.dbg_tx;                        // RULE_22
    assign raw[`CH_TIMER_BASE+:4]     = p.timer;                         // RULE_14
    assign raw[`CH_SBUS_HI]           = p.sbus_hi;                       // RULE_15
    assign raw[`CH_SBUS_LO]           = p.sbus_lo;                       // RULE_15
    assign raw[`CH_CLOCK]             = p.clock;                         // RULE_16
    assign raw[`CH_NET]               = p.net;                           // RULE_16
    assign raw[`CH_XFER]              = |p.xfer;                         // RULE_17
    assign raw[`CH_FIELD]             = p.field;                         // RULE_16
    assign raw[`CH_MOTOR]             = |p.motor;                        // RULE_16
    assign raw[`CH_CONV]              = p.conv;                          // RULE_16
    assign raw[`CH_ASYNC_BASE+:3]     = p.async;                         // RULE_18
    assign raw[`CH_TWI_BASE+:2]       = p.twi;                           // RULE_19
    assign raw[`CH_SYNC_BASE+:2]      = p.sync;                          // RULE_19
    assign raw[`CH_LOWV]              = p.lowv;                          // RULE_20
    assign raw[`CH_RTC]               = p.rtc;                           // RULE_20
    assign raw[`CH_WAKE_ALL]          = |wk;                             // RULE_11 RULE_09
    assign raw[`CH_WAKE_GRP0]         = |wgrp0;                          // RULE_12 RULE_09
    assign raw[`CH_WAKE_GRP0+1]       = |wk[13:6];                       // RULE_12
    assign raw[`CH_WAKE_GRP0+2]       = |wk[21:14];                      // RULE_12
    assign raw[`CH_WAKE_GRP0+3]       = |wk[29:22];                      // RULE_12
    assign raw[`CH_SBUS_RESUME]       = p.sbus_resume;                   // RULE_21
    assign raw[`CH_PREFETCH_BRANCH_CACHE_SRC]            = p.prefetch_branch_cache_src;                        // RULE_21

    // Forcing works regardless of the source level.
    ch_vec_t pend;
    assign pend = (raw | force_pend) & ch_enable;                        // RULE_10

    // ****************************************
    // Per-unit remap and priority
    // ****************************************
    // Each four-bit map field picks a source of the same unit, so no source can cross units.
    function automatic logic [15:0] remap(input logic [15:0] src, input logic [63:0] map);
        logic [15:0] r;
        r = 16'h0000;
        for (int i = 0; i < `CH_PER_UNIT; i++) begin
            r[i] = src[map[4*i+:4]];
        end
        return r;
    endfunction : remap

    function automatic logic [4:0] first_set(input logic [15:0] v);
        logic [4:0] r;
        r = 5'h10;
        for (int i = `CH_PER_UNIT-1; i >= 0; i--) begin
            if (v[i]) begin
                r = {1'b0, 4'(i)};
            end
        end
        return r;
    endfunction : first_set

    logic [15:0] prim_slots;
    logic [15:0] sec_slots;
    logic [15:0] prim_vec_slots;
    logic [15:0] sec_vec_slots;
    logic [4:0]  prim_win;
    logic [4:0]  sec_win;
    logic        sec_chain;
    assign prim_slots     = remap(pend[15:0], prim_map);                 // RULE_05
    assign sec_slots      = remap(pend[31:16], sec_map);                 // RULE_05
    assign prim_vec_slots = prim_slots & ~remap(fast_sel[15:0], prim_map);
    assign sec_vec_slots  = sec_slots & ~remap(fast_sel[31:16], sec_map);
    assign prim_win       = first_set(prim_vec_slots);                   // RULE_04
    assign sec_win        = first_set(sec_vec_slots);                    // RULE_04
    assign sec_chain      = ~sec_win[4];                                 // RULE_23

    logic    any_vec;
    logic    any_fast;
    ch_idx_t win_slot;
    vec_t    win_vec;
    assign any_vec  = ~prim_win[4] | sec_chain;                          // RULE_03
    assign any_fast = |(pend & fast_sel);                                // RULE_02
    assign win_slot = ~prim_win[4] ? {1'b0, prim_win[3:0]} : {1'b1, sec_win[3:0]}; // RULE_06
    assign win_vec  = vec_base + vec_t'(win_slot) * `VEC_STEP;

    // ****************************************
    // Service sequencing
    // ****************************************
    svc_e    state_r;
    svc_e    state_nxt;
    ch_idx_t src_r;
    vec_t    vec_r;
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            SVC_IDLE: begin
                if (any_vec) begin
                    state_nxt = SVC_PENDING;
                end
            end
            // A read wins over a request that lapses in the same cycle.
            SVC_PENDING: begin
                if (vec_read) begin
                    state_nxt = SVC_ACTIVE;
                end else if (!any_vec) begin
                    state_nxt = SVC_IDLE;
                end
            end
            // One cycle out of pending gives the serviced source time to drop.
            SVC_ACTIVE: begin
                state_nxt = SVC_IDLE;
            end
            default: begin
                state_nxt = SVC_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            state_r <= SVC_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Request outputs follow the channel levels through one register stage.
    always_ff @(posedge clock) begin
        if (srst) begin
            fast_irq_out    <= 1'b0;
            normal_irq_out  <= 1'b0;
            vec_valid       <= 1'b0;
            cache_vec_instr <= `VEC_RST;
        end else begin
            fast_irq_out    <= any_fast;                                 // RULE_01 RULE_02
            normal_irq_out  <= any_vec;                                  // RULE_03
            vec_valid       <= (state_nxt == SVC_PENDING);               // RULE_07
            cache_vec_instr <= vec_base;                                 // RULE_08
        end
    end

    // Winner is frozen once resolved so the service read sees a stable pair.
    // A higher request that arrives meanwhile waits for the next round.
    always_ff @(posedge clock) begin
        if (srst) begin
            src_r <= 5'h00;
            vec_r <= `VEC_RST;
        end else if (state_r != SVC_PENDING) begin
            src_r <= win_slot;                                           // RULE_07
            vec_r <= win_vec;
        end
    end
    assign src_out = src_r;
    assign vec_out = vec_r;

    // ****************************************
    // Checks
    // ****************************************
    prim_beats_sec_a: assert property (@(posedge clock) disable iff (srst) // RULE_06
        (|prim_vec_slots) |-> !win_slot[4])
        else $error("secondary won over pending primary");
    top_priority_a: assert property (@(posedge clock) disable iff (srst) // RULE_04
        prim_vec_slots[0] |-> (win_slot == 5'h00))
        else $error("slot zero did not win");
    normal_or_a: assert property (@(posedge clock) disable iff (srst) // RULE_03
        !$past(srst) |-> (normal_irq_out == $past(|(pend & ~fast_sel))))
        else $error("normal request not OR of channels");
    fast_follow_a: assert property (@(posedge clock) disable iff (srst) // RULE_02
        (any_fast && !srst) |=> fast_irq_out)
        else $error("fast request missed");
    force_pend_a: assert property (@(posedge clock) disable iff (srst) // RULE_10
        (force_pend[0] && ch_enable[0] && !fast_sel[0] && prim_map[3:0] == 4'h0) |-> prim_vec_slots[0])
        else $error("forced channel not pending");
    wake_all_a: assert property (@(posedge clock) disable iff (srst) // RULE_11
        raw[`CH_WAKE_ALL] == (|wk))
        else $error("wake all channel wrong");
    svc_read_a: assert property (@(posedge clock) disable iff (srst) // RULE_07
        (state_r == SVC_PENDING && vec_read) |=> (state_r == SVC_ACTIVE) ##1 (state_r == SVC_IDLE))
        else $error("service sequence broken");
    stable_vec_a: assert property (@(posedge clock) disable iff (srst) // RULE_07
        (state_r == SVC_PENDING) ##1 (state_r == SVC_PENDING) |-> $stable(vec_r))
        else $error("vector changed while pending");
    chain_in_a: assert property (@(posedge clock) disable iff (srst) // RULE_23
        (prim_win[4] && sec_chain) |-> (win_slot == {1'b1, sec_win[3:0]}))
        else $error("secondary not chained");

    // ****************************************
    // Request and source checks
    // ****************************************
    // Reset must silence every request output on the following edge.
    reset_quiet_a: assert property (@(posedge clock) // RULE_01
        srst
        |=> (!fast_irq_out && !normal_irq_out && !vec_valid))
        else $error("request output active after reset");

    // The first edge after reset sees a stale past value, so it is skipped.
    fast_exact_a: assert property (@(posedge clock) disable iff (srst) // RULE_02
        !$past(srst)
        |-> (fast_irq_out == $past(|(pend & fast_sel))))
        else $error("fast request not OR of routed channels");

    valid_normal_a: assert property (@(posedge clock) disable iff (srst) // RULE_07
        vec_valid
        |-> normal_irq_out)
        else $error("vector offered without normal request");

    // The vector is checked against its own arithmetic, not the adder above.
    vec_calc_a: assert property (@(posedge clock) disable iff (srst) // RULE_07
        $rose(vec_valid)
        |-> (vec_out == $past(vec_base) + {25'h0, src_out, 2'b00}))
        else $error("vector does not match winning slot");

    valid_drop_a: assert property (@(posedge clock) disable iff (srst) // RULE_07
        (vec_valid && vec_read)
        |=> !vec_valid)
        else $error("vector still offered after service read");

    cache_copy_a: assert property (@(posedge clock) disable iff (srst) // RULE_08
        !$past(srst)
        |-> (cache_vec_instr == $past(vec_base)))
        else $error("cache entry lost the vector read");

    sec_only_a: assert property (@(posedge clock) disable iff (srst) // RULE_23
        (!(|prim_vec_slots) && (|sec_vec_slots))
        |-> win_slot[4])
        else $error("secondary request not forwarded");

    sec_top_a: assert property (@(posedge clock) disable iff (srst) // RULE_04
        (!(|prim_vec_slots) && sec_vec_slots[0])
        |-> (win_slot == 5'h10))
        else $error("secondary slot zero did not win");

    // A source moved to slot zero must take that slot's priority.
    remap_slot_a: assert property (@(posedge clock) disable iff (srst) // RULE_05
        (prim_map[3:0] == 4'h3 && pend[3] && !fast_sel[3])
        |-> prim_vec_slots[0])
        else $error("remapped source not in its slot");

    watchdog_path_a: assert property (@(posedge clock) disable iff (srst) // RULE_13
        (p.watchdog && ch_enable[`CH_WATCHDOG] && !fast_sel[`CH_WATCHDOG] && prim_map[3:0] == 4'h0)
        |=> normal_irq_out)
        else $error("watchdog request lost");

    wake_group_a: assert property (@(posedge clock) disable iff (srst) // RULE_12
        (wk[`WAKE_ALARM_BIT] && ch_enable[`CH_WAKE_GRP0])
        |-> pend[`CH_WAKE_GRP0])
        else $error("alarm missing from wake group zero");

    xfer_any_a: assert property (@(posedge clock) disable iff (srst) // RULE_17
        ((|p.xfer) && ch_enable[`CH_XFER])
        |-> pend[`CH_XFER])
        else $error("transfer engine request lost");

    motor_any_a: assert property (@(posedge clock) disable iff (srst) // RULE_16
        ((|p.motor) && ch_enable[`CH_MOTOR])
        |-> pend[`CH_MOTOR])
        else $error("motor request lost");

    // A disabled channel must stay quiet even while its sources are active.
    disabled_quiet_a: assert property (@(posedge clock) disable iff (srst) // RULE_11
        !ch_enable[`CH_WAKE_ALL]
        |-> !pend[`CH_WAKE_ALL])
        else $error("disabled channel pending");
endmodule : dual_vectored_interrupt_ctrl

// File: design/intc_params.svh
// Constants for the dual vectored interrupt controller.
// Assumes inclusion by the package and the controller module only.
`ifndef INTC_PARAMS_SVH
`define INTC_PARAMS_SVH
`define CH_TOTAL        32
`define CH_PER_UNIT     16
`define CH_IDX_W        5
`define LOC_IDX_W       4
`define VEC_W           32
`define WAKE_IN_W       32
`define WAKE_GRP_W      8
`define CH_WATCHDOG     0
`define CH_FW_SOFT      1
`define CH_DBG_RX       2
`define CH_DBG_TX       3
`define CH_TIMER_BASE   4
`define CH_SBUS_HI      8
`define CH_SBUS_LO      9
`define CH_CLOCK        10
`define CH_NET          11
`define CH_XFER         12
`define CH_FIELD        13
`define CH_MOTOR        14
`define CH_CONV         15
`define CH_ASYNC_BASE   16
`define CH_TWI_BASE     19
`define CH_SYNC_BASE    21
`define CH_LOWV         23
`define CH_RTC          24
`define CH_WAKE_ALL     25
`define CH_WAKE_GRP0    26
`define CH_SBUS_RESUME  30
`define CH_PREFETCH_BRANCH_CACHE_SRC       31
`define WAKE_ALARM_BIT  30
`define WAKE_RESUME_BIT 31
`define VEC_RST         32'h0000_0000
`define VEC_STEP        32'h0000_0004
`endif

// File: design/intc_pkg.sv
// Types shared by the interrupt controller and its neighbours.
// Assumes intc_params.svh is on the include path.
`include "intc_params.svh"
package intc_pkg;
    typedef logic [`CH_TOTAL-1:0]  ch_vec_t;
    typedef logic [`CH_IDX_W-1:0]  ch_idx_t;
    typedef logic [`VEC_W-1:0]     vec_t;
    typedef struct packed {
        logic [3:0] timer;   // One flag group per timer, already ORed by the timer.
        logic       sbus_hi;
        logic       sbus_lo;
        logic       clock;
        logic       net;
        logic [7:0] xfer;
        logic       field;
        logic [7:0] motor;
        logic       conv;
        logic [2:0] async;
        logic [1:0] twi;
        logic [1:0] sync;
        logic       lowv;
        logic       rtc;
        logic       sbus_resume;
        logic       prefetch_branch_cache_src;
        logic       watchdog;
        logic       dbg_rx;
        logic       dbg_tx;
    } periph_s;
    typedef enum logic [1:0] {
        SVC_IDLE,
        SVC_PENDING,
        SVC_ACTIVE
    } svc_e;
endpackage : intc_pkg

// File: testbench/core_model.sv
// Core-side model: answers each vectored request with one service read.
// Assumes the controller's clock and synchronous reset.
`timescale 1ns/1ps
module core_model (
    // Clock and reset
    input  wire logic clock,
    input  wire logic srst,
    // Request and service read
    input  wire logic vec_valid,
    output logic      vec_read
);
    // The read follows the request at once: the bench drops the source on that
    // edge, and a read more than two cycles later would find the pending state already lapsed.
    initial begin
        vec_read = 1'b0;
        forever begin
            @(posedge clock);
            if (!srst && vec_valid) begin
                vec_read <= 1'b1;
                @(posedge clock);
                vec_read <= 1'b0;
                repeat (2) @(posedge clock);
            end
        end
    end
endmodule : core_model

// File: testbench/test_dual_vectored_interrupt_ctrl.sv
// Self-checking bench for the dual vectored interrupt controller.
// Assumes core_model answers service reads.
`timescale 1ns/1ps
module test_dual_vectored_interrupt_ctrl;
    import intc_pkg::*;
    localparam logic [63:0] IDENT = 64'hfedcba9876543210;
    logic          clock, srst, fw_soft_irq, vec_read, fast_irq_out, normal_irq_out, vec_valid, prev_valid;
    periph_s       periph;
    logic [31:0]   wake_in;
    ch_vec_t       fast_sel, force_pend, ch_enable;
    logic [63:0]   prim_map, sec_map;
    vec_t          vec_base, vec_out, cache_vec_instr;
    ch_idx_t       src_out;
    int            fails, comparisons, cycles, r, a, b;
    logic [37:0]   notes[$];

    dual_vectored_interrupt_ctrl dut (.clock(clock), .srst(srst), .periph(periph), .wake_in(wake_in),
        .fw_soft_irq(fw_soft_irq), .fast_sel(fast_sel), .force_pend(force_pend), .ch_enable(ch_enable),
        .prim_map(prim_map), .sec_map(sec_map), .vec_base(vec_base), .vec_read(vec_read),
        .fast_irq_out(fast_irq_out), .normal_irq_out(normal_irq_out), .src_out(src_out),
        .vec_out(vec_out), .vec_valid(vec_valid), .cache_vec_instr(cache_vec_instr));
    core_model partner (.clock(clock), .srst(srst), .vec_valid(vec_valid), .vec_read(vec_read));

    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            stop_test();
        end
    end

    task check(input logic [37:0] seen, input logic [37:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task stop_test;
        if (notes.size() != 0) fails++;
        $display("fails=%0d comparisons=%0d", fails, comparisons);
        if (fails == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : stop_test

    // ********************************
    // Result watcher
    // ********************************
    always @(negedge clock) begin
        prev_valid <= vec_valid;
        if (vec_valid === 1'b1 && prev_valid === 1'b0)
            check({normal_irq_out, src_out, vec_out}, notes.size() ? notes.pop_front() : 'x);
    end

    function automatic logic [63:0] swap(input int s);
        logic [63:0] m;
        m = IDENT;
        m[3:0] = 4'(s);
        m[4*s +: 4] = 4'h0;
        return m;
    endfunction : swap

    task serve(input int ch);
        notes.push_back({1'b1, 5'(ch), vec_base + 32'(4 * ch)});
        for (int i = 0; i < 60 && vec_valid !== 1'b1; i++) @(negedge clock);
        @(posedge clock);
        periph <= '0;
        wake_in <= '0;
        fw_soft_irq <= 1'b0;
        force_pend <= '0;
        for (int i = 0; i < 60 && vec_valid !== 1'b0; i++) @(negedge clock);
        repeat (4) @(posedge clock);
    endtask : serve

    task drive_src(input int k);
        @(posedge clock);
        ch_enable <= (k inside {[26:29]}) ? ~32'h0200_0000 : '1;
        case (k)
            0: periph.watchdog <= 1'b1;
            1: fw_soft_irq <= 1'b1;
            2: periph.dbg_rx <= 1'b1;
            3: periph.dbg_tx <= 1'b1;
            4, 5, 6, 7: periph.timer[k-4] <= 1'b1;
            8: periph.sbus_hi <= 1'b1;
            9: periph.sbus_lo <= 1'b1;
            10: periph.clock <= 1'b1;
            11: periph.net <= 1'b1;
            12: periph.xfer[r%8] <= 1'b1;
            13: periph.field <= 1'b1;
            14: periph.motor[r%8] <= 1'b1;
            15: periph.conv <= 1'b1;
            16, 17, 18: periph.async[k-16] <= 1'b1;
            19, 20: periph.twi[k-19] <= 1'b1;
            21, 22: periph.sync[k-21] <= 1'b1;
            23: periph.lowv <= 1'b1;
            24: periph.rtc <= 1'b1;
            25: wake_in[r%32] <= 1'b1;
            26: wake_in[(r%8 < 6) ? r%8 : 24+r%8] <= 1'b1;
            27, 28, 29: wake_in[8*(k-26)-2+r%8] <= 1'b1;
            30: periph.sbus_resume <= 1'b1;
            default: periph.prefetch_branch_cache_src <= 1'b1;
        endcase
    endtask : drive_src

    // ********************************
    // Main sequence
    // ********************************
    initial begin
        void'($urandom(92));
        {srst, prev_valid, fw_soft_irq} = 3'b100;
        periph = '0;
        wake_in = '0;
        {fast_sel, force_pend} = '0;
        ch_enable = '1;
        {prim_map, sec_map} = {IDENT, IDENT};
        vec_base = $urandom();
        {fails, comparisons, cycles} = '0;
        repeat (11) @(posedge clock);
        @(negedge clock);
        check({normal_irq_out, fast_irq_out, vec_valid}, 38'h0);
        @(posedge clock);
        srst <= 1'b0;
        for (int k = 0; k < 32; k++) begin
            r = $urandom_range(255, 0);
            drive_src(k);
            serve(k);
        end
        for (int n = 0; n < 10; n++) begin
            a = $urandom_range(30, 0);
            b = $urandom_range(31, a + 1);
            @(posedge clock);
            force_pend <= (32'h1 << a) | (32'h1 << b);
            serve(a);
        end
        for (int n = 0; n < 4; n++) begin
            a = $urandom_range(31, 0);
            b = (a + 1 + $urandom_range(30, 0)) % 32;
            @(posedge clock);
            fast_sel <= 32'h1 << a;
            force_pend <= (32'h1 << a) | (32'h1 << b);
            fork
                serve(b);
                begin
                    for (int i = 0; i < 10 && fast_irq_out !== 1'b1; i++) @(negedge clock);
                    check(fast_irq_out, 38'h1);
                end
            join
            fast_sel <= '0;
        end
        @(posedge clock);
        prim_map <= swap(3);
        force_pend <= 32'h0000_000a;
        serve(0);
        for (int n = 0; n < 4; n++) begin
            a = $urandom_range(15, 0);
            b = $urandom_range(15, 1);
            @(posedge clock);
            prim_map <= IDENT;
            sec_map <= swap(b);
            force_pend <= (32'h1 << a) | (32'h1 << (16 + b));
            serve(a);
            force_pend <= 32'h1 << (16 + b);
            serve(16);
        end
        check(cache_vec_instr, vec_base);
        stop_test();
    end
endmodule : test_dual_vectored_interrupt_ctrl
